// ---- pkg/dag_pkg.sv ----
// Constants, modes, states and carrier structs of the data address generator
package dag_pkg;
   // Data-space areas
   localparam logic [15:0] DAG_RAM_LAST = 16'hfdff;
   localparam logic [15:0] DAG_SFR_BASE = 16'hfe00;
   localparam logic [15:0] DAG_SFR_LAST = 16'hfeff;
   localparam logic [15:0] DAG_SYS_BASE = 16'hff00;
   localparam logic [7:0] DAG_SFR_HI = 8'hfe;
   localparam logic [7:0] DAG_SYS_HI = 8'hff;
   // Core registers in the special-function area
   localparam logic [15:0] DAG_ACC_ADDR = 16'hfe00;
   localparam logic [15:0] DAG_HIGH_ADDR = 16'hfe01;
   localparam logic [15:0] DAG_INDEX_ADDR = 16'hfe02;
   // Byte returned by a load that overflows the RAM area
   localparam logic [7:0] DAG_OVF_BYTE = 8'hff;
   // Instruction lengths of direct forms
   localparam logic [1:0] DAG_SHORT_BYTES = 2'h2;
   localparam logic [1:0] DAG_LONG_BYTES = 2'h3;
   // Pointer count and cycles from a taken pointer request to its result
   localparam int DAG_POINTERS = 64;
   localparam int DAG_PTR_LATENCY = 4;

   typedef enum logic [2:0] {
      DAG_M_IMM = 3'h0,
      DAG_M_PTR = 3'h1,
      DAG_M_PTR_IDX = 3'h2,
      DAG_M_DISP = 3'h3,
      DAG_M_DIRECT = 3'h4,
      DAG_M_TABLE = 3'h5,
      DAG_M_EXTERN = 3'h6
   } dag_mode_t;

   typedef enum logic [1:0] {
      DAG_A_RAM = 2'h0,
      DAG_A_SFR = 2'h1,
      DAG_A_SYS = 2'h2
   } dag_area_t;

   // Gray-coded walk: idle, low byte, high byte, calculate
   typedef enum logic [1:0] {
      DAG_S_IDLE = 2'b00,
      DAG_S_RD_LO = 2'b01,
      DAG_S_RD_HI = 2'b11,
      DAG_S_CALC = 2'b10
   } dag_state_t;

   typedef struct packed {
      logic valid;
      dag_mode_t mode;
      logic [5:0] ptr_sel;
      logic [7:0] index;
      logic [6:0] disp;
      logic [15:0] direct;
      logic [15:0] imm;
      logic imm_word;
      logic long_load_form;
   } dag_req_t;

   typedef struct packed {
      logic valid;
      dag_mode_t mode;
      logic [15:0] base;
      logic [15:0] sum;
      logic [15:0] addr;
      dag_area_t area;
      logic force_ff;
      logic [15:0] value;
      logic imm_word;
      logic acc_sel;
      logic high_sel;
      logic index_sel;
      logic [1:0] instr_bytes;
   } dag_res_t;

   typedef struct packed {
      dag_state_t st;
      dag_mode_t mode;
      logic [7:0] index;
      logic [6:0] disp;
      logic [7:0] lo;
      logic ram_rd;
      logic [15:0] ram_addr;
      logic ready;
      dag_res_t res;
   } dag_regs_t;
endpackage

// ---- src/dag_core.sv ----
// Effective-address generator for data memory of the 8-bit core
//
// Operation
// - Seven modes: immediate, pointer, pointer+index, displacement, direct, table, external.
// - Immediate operand comes from the instruction, one byte or one word wide.
// - Pointer mode selects one of 64 pointers; its value is the address unchanged.
// - Pointer read from two consecutive RAM bytes, low byte first.
// - The 64 pointers live in ordinary RAM at bytes 0 to 7FH.
// - Pointer+index adds the index register as a signed byte.
// - Displacement mode adds a signed 7-bit value to pointer zero.
// - Areas: RAM to FDFFH, special function FE00H-FEFFH, reserved FF00H up.
// - The unmodified pointer fixes the area; the sum may not leave it.
// - RAM base with sum outside RAM makes a byte load return 0FFH.
// - Special-function base keeps only the low sum byte, added to FE00H.
// - Same confinement applies to the displacement mode.
// - Computed addresses in the special-function area reach the core registers.
// - Accumulator FE00H, high operand FE01H, index register FE02H.
// - Direct mode uses the operand address with no arithmetic.
// - Direct forms differ in length; the long load form has fixed three bytes.
`timescale 1ns/1ps
`default_nettype none
module dag_core (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire dag_pkg::dag_req_t req_i,
   output logic ready_o,
   output logic ram_rd_o,
   output logic [15:0] ram_addr_o,
   input wire logic [7:0] ram_rdata_i,
   output dag_pkg::dag_res_t res_o
);
   import dag_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Area decode of a 16-bit data address
   function automatic dag_area_t area_of(input logic [15:0] a);
      if (a <= DAG_RAM_LAST) begin
         area_of = DAG_A_RAM;
      end else if (a <= DAG_SFR_LAST) begin
         area_of = DAG_A_SFR;
      end else begin
         area_of = DAG_A_SYS;
      end
   endfunction

   // Fill the result for a final address, with core register hits
   function automatic dag_res_t finish(input dag_mode_t m, input logic [15:0] base,
                                       input logic [15:0] sum, input logic [15:0] addr,
                                       input logic ovf);
      dag_res_t r;
      r = '0;
      r.valid = 1'b1;
      r.mode = m;
      r.base = base;
      r.sum = sum;
      r.addr = addr;
      // Area follows the unmodified base, so an overflowed RAM sum still reports RAM
      r.area = area_of(base);
      r.force_ff = ovf;
      r.value = ovf ? {8'h00, DAG_OVF_BYTE} : 16'h0000;
      r.acc_sel = !ovf && addr == DAG_ACC_ADDR;
      r.high_sel = !ovf && addr == DAG_HIGH_ADDR;
      r.index_sel = !ovf && addr == DAG_INDEX_ADDR;
      finish = r;
   endfunction

   // Confine an indexed sum to the area of its base
   function automatic dag_res_t confine(input dag_mode_t m, input logic [15:0] base,
                                        input logic [15:0] sum);
      dag_res_t r;
      r = '0;
      case (area_of(base))
         DAG_A_RAM: begin
            // Overflow keeps the address but suppresses the access
            r = finish(m, base, sum, sum, area_of(sum) != DAG_A_RAM);
         end
         DAG_A_SFR: begin
            r = finish(m, base, sum, {DAG_SFR_HI, sum[7:0]}, 1'b0);
         end
         default: begin
            // Reserved area wraps in its own page the same way
            r = finish(m, base, sum, {DAG_SYS_HI, sum[7:0]}, 1'b0);
         end
      endcase
      confine = r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   dag_regs_t q_r;
   dag_regs_t q_nxt;
   logic take;
   logic [15:0] ptr_val;
   logic [15:0] sum_idx;
   logic [15:0] sum_disp;

   assign take = req_i.valid && q_r.ready;
   // High byte arrives now, low byte was caught one cycle earlier
   assign ptr_val = {ram_rdata_i, q_r.lo};
   // Sign extension before the add keeps negative steps exact
   assign sum_idx = ptr_val + {{8{q_r.index[7]}}, q_r.index};
   assign sum_disp = ptr_val + {{9{q_r.disp[6]}}, q_r.disp};

   // Next-state logic; RAM answers one cycle after each read strobe
   always_comb begin
      q_nxt = q_r;
      q_nxt.res.valid = 1'b0;
      q_nxt.ram_rd = 1'b0;
      case (q_r.st)
         DAG_S_IDLE: begin
            if (take) begin
               case (req_i.mode)
                  DAG_M_IMM: begin
                     q_nxt.res = '0;
                     q_nxt.res.valid = 1'b1;
                     q_nxt.res.mode = req_i.mode;
                     q_nxt.res.imm_word = req_i.imm_word;
                     // Byte form zero-fills the upper half
                     q_nxt.res.value = req_i.imm_word ? req_i.imm : {8'h00, req_i.imm[7:0]};
                  end
                  DAG_M_DIRECT: begin
                     q_nxt.res = finish(req_i.mode, req_i.direct, req_i.direct,
                                        req_i.direct, 1'b0);
                     q_nxt.res.instr_bytes = req_i.long_load_form ? DAG_LONG_BYTES
                                                                  : DAG_SHORT_BYTES;
                  end
                  DAG_M_PTR, DAG_M_PTR_IDX, DAG_M_DISP, DAG_M_TABLE, DAG_M_EXTERN: begin
                     q_nxt.st = DAG_S_RD_LO;
                     q_nxt.ready = 1'b0;
                     q_nxt.mode = req_i.mode;
                     q_nxt.index = req_i.index;
                     q_nxt.disp = req_i.disp;
                     q_nxt.ram_rd = 1'b1;
                     // Pointer n sits at RAM bytes 2n and 2n+1; zero for displacement
                     q_nxt.ram_addr = (req_i.mode == DAG_M_DISP) ? 16'h0000
                                      : {9'h000, req_i.ptr_sel, 1'b0};
                  end
                  default: begin
                     q_nxt.res = '0; // Undefined code: answered as empty immediate
                     q_nxt.res.valid = 1'b1;
                  end
               endcase
            end
         end
         DAG_S_RD_LO: begin
            q_nxt.st = DAG_S_RD_HI;
            q_nxt.ram_rd = 1'b1;
            q_nxt.ram_addr = q_r.ram_addr + 16'h0001;
         end
         DAG_S_RD_HI: begin
            q_nxt.st = DAG_S_CALC;
            q_nxt.lo = ram_rdata_i; // Low byte first
         end
         DAG_S_CALC: begin
            q_nxt.st = DAG_S_IDLE;
            q_nxt.ready = 1'b1;
            case (q_r.mode)
               DAG_M_PTR_IDX: q_nxt.res = confine(q_r.mode, ptr_val, sum_idx);
               DAG_M_DISP: q_nxt.res = confine(q_r.mode, ptr_val, sum_disp);
               // Plain pointer, and the low word handed on for table and external use
               default: q_nxt.res = finish(q_r.mode, ptr_val, ptr_val, ptr_val, 1'b0);
            endcase
         end
         default: begin
            q_nxt.st = DAG_S_IDLE;
            q_nxt.ready = 1'b1;
         end
      endcase
   end

   // Single register bank for all state
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         q_r <= '0;
         q_r.ready <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign ready_o = q_r.ready;
   assign ram_rd_o = q_r.ram_rd;
   assign ram_addr_o = q_r.ram_addr;
   assign res_o = q_r.res;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   logic ptr_mode;
   assign ptr_mode = req_i.mode inside {DAG_M_PTR, DAG_M_PTR_IDX, DAG_M_TABLE, DAG_M_EXTERN};

   property p_ptr_lo;
      @(posedge clock_i) disable iff (!rst_n_i)
      take && ptr_mode |=> ram_rd_o && ram_addr_o == {9'h000, $past(req_i.ptr_sel), 1'b0};
   endproperty
   a_ptr_lo: assert property (p_ptr_lo) else $error("pointer low byte address wrong");

   property p_ptr_hi;
      @(posedge clock_i) disable iff (!rst_n_i)
      ram_rd_o && q_r.st == DAG_S_RD_LO |=> ram_rd_o && ram_addr_o == $past(ram_addr_o) + 16'h1;
   endproperty
   a_ptr_hi: assert property (p_ptr_hi) else $error("pointer high byte not next");

   property p_imm;
      @(posedge clock_i) disable iff (!rst_n_i)
      take && req_i.mode == DAG_M_IMM && !req_i.imm_word
      |=> res_o.valid && res_o.value == {8'h00, $past(req_i.imm[7:0])};
   endproperty
   a_imm: assert property (p_imm) else $error("byte immediate wrong");

   property p_direct;
      @(posedge clock_i) disable iff (!rst_n_i)
      take && req_i.mode == DAG_M_DIRECT |=> res_o.valid && res_o.addr == $past(req_i.direct)
         && res_o.instr_bytes == ($past(req_i.long_load_form) ? 2'h3 : 2'h2);
   endproperty
   a_direct: assert property (p_direct) else $error("direct address or length wrong");

   property p_ptr_plain;
      @(posedge clock_i) disable iff (!rst_n_i)
      take && req_i.mode == DAG_M_PTR
      |-> ##4 res_o.valid && res_o.addr == {$past(ram_rdata_i, 1), $past(ram_rdata_i, 2)};
   endproperty
   a_ptr_plain: assert property (p_ptr_plain) else $error("pointer value altered");

   property p_busy;
      @(posedge clock_i) disable iff (!rst_n_i)
      take && ptr_mode |=> !ready_o [*3] ##1 ready_o;
   endproperty
   a_busy: assert property (p_busy) else $error("pointer sequence length wrong");

   property p_sfr_wrap;
      @(posedge clock_i) disable iff (!rst_n_i)
      res_o.valid && res_o.mode inside {DAG_M_PTR_IDX, DAG_M_DISP}
         && res_o.base[15:8] == 8'hfe |-> res_o.addr == {8'hfe, res_o.sum[7:0]};
   endproperty
   a_sfr_wrap: assert property (p_sfr_wrap) else $error("area wrap lost");

   property p_ram_ovf;
      @(posedge clock_i) disable iff (!rst_n_i)
      res_o.valid && res_o.mode inside {DAG_M_PTR_IDX, DAG_M_DISP} && res_o.base <= 16'hfdff
         |-> res_o.force_ff == (res_o.sum > 16'hfdff)
             && (!res_o.force_ff || res_o.value == 16'h00ff);
   endproperty
   a_ram_ovf: assert property (p_ram_ovf) else $error("RAM overflow not flagged");

   property p_index_sel;
      @(posedge clock_i) disable iff (!rst_n_i)
      res_o.valid && !res_o.force_ff && res_o.mode != DAG_M_IMM
         |-> res_o.index_sel == (res_o.addr == 16'hfe02)
             && res_o.acc_sel == (res_o.addr == 16'hfe00);
   endproperty
   a_index_sel: assert property (p_index_sel) else $error("core register select wrong");
endmodule // dag_core
`default_nettype wire

// ---- verification/dag_core_tb_top.sv ----
// Self-checking testbench of the data address generator
`timescale 1ns/1ps
`default_nettype none
module dag_core_tb_top;
   import dag_pkg::*;
   typedef struct packed {
      dag_mode_t mode;
      logic [5:0] sel;
      logic [7:0] idx;
      logic [6:0] disp;
      logic [15:0] dv;
      logic flag;
      logic [15:0] exp;
      logic ff;
      dag_area_t area;
   } dag_row_t;
   logic clock;
   logic rst_n;
   dag_req_t req;
   logic ready;
   logic ram_rd;
   logic [15:0] ram_addr;
   logic [7:0] ram_rdata;
   dag_res_t res;
   logic [7:0] mem [0:127];
   int n_fail;
   int checks_done;
   int n_res;
   logic drop;
   // Mode, pointer, index, displacement, operand, flag, expected, overflow, area
   dag_row_t rows [0:19] = '{
      '{DAG_M_IMM, 6'h00, 8'h00, 7'h00, 16'h0012, 1'b0, 16'h0012, 1'b0, DAG_A_RAM},
      '{DAG_M_IMM, 6'h00, 8'h00, 7'h00, 16'h1234, 1'b1, 16'h1234, 1'b0, DAG_A_RAM},
      '{DAG_M_PTR, 6'h03, 8'h00, 7'h00, 16'h0123, 1'b0, 16'h0123, 1'b0, DAG_A_RAM},
      '{DAG_M_PTR, 6'h3f, 8'h00, 7'h00, 16'hfe02, 1'b0, 16'hfe02, 1'b0, DAG_A_SFR},
      '{DAG_M_PTR_IDX, 6'h03, 8'h02, 7'h00, 16'h0123, 1'b0, 16'h0125, 1'b0, DAG_A_RAM},
      '{DAG_M_PTR_IDX, 6'h05, 8'h01, 7'h00, 16'hfdff, 1'b0, 16'hfe00, 1'b1, DAG_A_RAM},
      '{DAG_M_PTR_IDX, 6'h05, 8'h02, 7'h00, 16'hfeff, 1'b0, 16'hfe01, 1'b0, DAG_A_SFR},
      '{DAG_M_PTR_IDX, 6'h3f, 8'h80, 7'h00, 16'hfe02, 1'b0, 16'hfe82, 1'b0, DAG_A_SFR},
      '{DAG_M_PTR_IDX, 6'h01, 8'h80, 7'h00, 16'h0005, 1'b0, 16'hff85, 1'b1, DAG_A_RAM},
      '{DAG_M_PTR_IDX, 6'h02, 8'h7f, 7'h00, 16'h0100, 1'b0, 16'h017f, 1'b0, DAG_A_RAM},
      '{DAG_M_DISP, 6'h00, 8'h00, 7'h7e, 16'hfe02, 1'b0, 16'hfe00, 1'b0, DAG_A_SFR},
      '{DAG_M_DISP, 6'h00, 8'h00, 7'h10, 16'h0123, 1'b0, 16'h0133, 1'b0, DAG_A_RAM},
      '{DAG_M_DISP, 6'h00, 8'h00, 7'h01, 16'hfdff, 1'b0, 16'hfe00, 1'b1, DAG_A_RAM},
      '{DAG_M_DISP, 6'h00, 8'h00, 7'h02, 16'hfeff, 1'b0, 16'hfe01, 1'b0, DAG_A_SFR},
      '{DAG_M_DISP, 6'h00, 8'h00, 7'h40, 16'h0040, 1'b0, 16'h0000, 1'b0, DAG_A_RAM},
      '{DAG_M_DIRECT, 6'h00, 8'h00, 7'h00, 16'h0123, 1'b0, 16'h0123, 1'b0, DAG_A_RAM},
      '{DAG_M_DIRECT, 6'h00, 8'h00, 7'h00, 16'h0123, 1'b1, 16'h0123, 1'b0, DAG_A_RAM},
      '{DAG_M_DIRECT, 6'h00, 8'h00, 7'h00, 16'hfe01, 1'b0, 16'hfe01, 1'b0, DAG_A_SFR},
      '{DAG_M_TABLE, 6'h04, 8'h00, 7'h00, 16'h1234, 1'b0, 16'h1234, 1'b0, DAG_A_RAM},
      '{DAG_M_EXTERN, 6'h04, 8'h00, 7'h00, 16'h0456, 1'b0, 16'h0456, 1'b0, DAG_A_RAM}};

   dag_core dut_u (.clock_i(clock), .rst_n_i(rst_n), .req_i(req), .ready_o(ready),
      .ram_rd_o(ram_rd), .ram_addr_o(ram_addr), .ram_rdata_i(ram_rdata), .res_o(res));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, and a RAM answering one cycle after each strobe
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Between reads the data lines toggle, so a stale byte is never mistaken for data
   always @(posedge clock) begin
      if (ram_rd === 1'b1) ram_rdata <= mem[ram_addr[6:0]];
      else ram_rdata <= ~ram_rdata;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and row runner
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic reset_chk;
      chk("ready in reset", 16'h1, {15'h0, ready});
      chk("strobe in reset", 16'h0, {15'h0, ram_rd});
      chk("result cleared", 16'h1, {15'h0, res === '0});
   endtask
   task automatic run_row(input dag_row_t r);
      int k;
      int lat;
      logic [2:0] sel;
      lat = (r.mode == DAG_M_IMM || r.mode == DAG_M_DIRECT) ? 1 : DAG_PTR_LATENCY;
      sel = r.ff ? 3'h0
                 : {r.exp == DAG_ACC_ADDR, r.exp == DAG_HIGH_ADDR, r.exp == DAG_INDEX_ADDR};
      mem[{r.sel, 1'b0}] = r.dv[7:0];
      mem[{r.sel, 1'b1}] = r.dv[15:8];
      @(posedge clock);
      req <= '{1'b1, r.mode, r.sel, r.idx, r.disp, r.dv, r.dv, r.flag, r.flag};
      @(posedge clock);
      req.valid <= 1'b0;
      k = 0;
      // The first look is just after the taking edge, where a one-cycle answer stands
      do begin
         if (k > 0) @(posedge clock);
         #1;
         k++;
         if (lat == 4 && k == 1) begin
            chk("low strobe", 16'h1, {15'h0, ram_rd});
            chk("low address", {9'h0, r.sel, 1'b0}, ram_addr);
            chk("busy", 16'h0, {15'h0, ready});
         end
         if (lat == 4 && k == 2) chk("high address", {9'h0, r.sel, 1'b1}, ram_addr);
      end while (res.valid !== 1'b1 && k < 8);
      chk("latency", lat[15:0], k[15:0]);
      chk("mode", {13'h0, r.mode}, {13'h0, res.mode});
      if (r.mode == DAG_M_IMM) begin
         chk("immediate", r.exp, res.value);
         chk("immediate width", {15'h0, r.flag}, {15'h0, res.imm_word});
      end else begin
         chk("address", r.exp, res.addr);
         chk("base", r.dv, res.base);
         chk("overflow", {15'h0, r.ff}, {15'h0, res.force_ff});
         if (r.ff) chk("overflow byte", {8'h0, DAG_OVF_BYTE}, res.value);
         chk("area", {14'h0, r.area}, {14'h0, res.area});
         chk("core select", {13'h0, sel},
             {13'h0, res.acc_sel, res.high_sel, res.index_sel});
      end
      chk("length", (r.mode == DAG_M_DIRECT) ? (r.flag ? 16'h3 : 16'h2) : 16'h0,
          {14'h0, res.instr_bytes});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog: the whole run needs well under 400 cycles
   initial begin
      repeat (3000) @(posedge clock);
      n_fail++;
      print_verdict();
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      req = '0;
      ram_rdata = 8'h00;
      drop = 1'b0;
      n_res = 0;
      n_fail = 0;
      checks_done = 0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      #1 reset_chk();
      foreach (rows[i]) run_row(rows[i]);
      // Directs back to back, one taken every cycle
      @(posedge clock);
      req <= '{valid: 1'b1, mode: DAG_M_DIRECT, direct: 16'h0aaa, default: '0};
      @(posedge clock);
      req.direct <= 16'h0bbb;
      #1 chk("first direct", 16'h0aaa, res.addr);
      @(posedge clock);
      req.direct <= 16'h0ccc;
      #1 chk("second direct", 16'h0bbb, res.addr);
      @(posedge clock);
      req.valid <= 1'b0;
      #1 chk("third direct", 16'h0ccc, res.addr);
      // A pointer request held while busy must be taken once, after the first walk
      mem[8] = 8'h34;
      mem[9] = 8'h12;
      mem[10] = 8'h77;
      mem[11] = 8'h07;
      @(posedge clock);
      req <= '{valid: 1'b1, mode: DAG_M_PTR, ptr_sel: 6'h04, default: '0};
      @(posedge clock);
      req.ptr_sel <= 6'h05;
      for (int k = 1; k <= 14; k++) begin
         @(posedge clock);
         if (drop) req.valid <= 1'b0;
         #1;
         if (res.valid === 1'b1) begin
            chk("held order", (n_res == 0) ? 16'h1234 : 16'h0777, res.addr);
            // k counts edges after the taking one, so the answer is seen one earlier
            if (n_res == 0) chk("first walk time", 16'(DAG_PTR_LATENCY - 1), k[15:0]);
            n_res++;
         end
         if (n_res >= 1 && ready === 1'b0) drop = 1'b1;
      end
      chk("results of held requests", 16'h2, n_res[15:0]);
      // Reset in mid-walk abandons the request
      @(posedge clock);
      req <= '{valid: 1'b1, mode: DAG_M_PTR, ptr_sel: 6'h04, default: '0};
      @(posedge clock);
      req.valid <= 1'b0;
      @(posedge clock);
      rst_n <= 1'b0;
      @(posedge clock);
      #1 reset_chk();
      @(posedge clock);
      rst_n <= 1'b1;
      repeat (5) @(posedge clock);
      #1 chk("no stale result", 16'h0, {15'h0, res.valid});
      print_verdict();
   end
endmodule // dag_core_tb_top
`default_nettype wire
